//--- cpt_hazard_cmp.sv
// Package of shared constants and instruction classes for the pipeline
// issue control, plus the per-stage hazard comparator.
// Assumes one processor clock and decoded instruction fields at issue.

// ============================================================
// Shared definitions
package cpt_pkg;
  localparam int REG_W = 4;
  localparam int STG_W = 3;
  localparam int CNT_W = 4;
  localparam logic [STG_W-1:0] STAGES_LONG = 3'h5;
  localparam logic [STG_W-1:0] STAGES_SHORT = 3'h4;
  localparam logic [STG_W-1:0] BASE_CYCLES = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
  localparam logic [REG_W-1:0] REG_ZERO = 4'h0;

  typedef enum logic [2:0] {
    CLS_REG_XFER,
    CLS_LOAD,
    CLS_STORE,
    CLS_STORE_PREDEC,
    CLS_PREFETCH,
    CLS_REG_ARITH,
    CLS_SR_ARITH
  } cpt_class_type;

  typedef enum logic {
    SLOT_NORMAL,
    SLOT_SPLIT
  } cpt_slot_type;

  typedef struct packed {
    logic valid;
    cpt_class_type cls;
    logic [REG_W-1:0] dst;
  } cpt_entry_type;

  // Ordinary stores and the cache prefetch have no write-back stage.
  function automatic logic [STG_W-1:0] cls_stages(cpt_class_type c);
    if (c == CLS_STORE || c == CLS_PREFETCH) begin
      return STAGES_SHORT;
    end
    return STAGES_LONG;
  endfunction : cls_stages

  function automatic logic cls_has_mem(cpt_class_type c);
    return c == CLS_LOAD || c == CLS_STORE || c == CLS_STORE_PREDEC ||
           c == CLS_PREFETCH;
  endfunction : cls_has_mem

  function automatic logic cls_writes_reg(cpt_class_type c);
    return cls_stages(c) == STAGES_LONG;
  endfunction : cls_writes_reg
endpackage : cpt_pkg

`timescale 1ns/1ps

// ============================================================
// Hazard comparator for one in-flight pipeline entry
module cpt_hazard_cmp
  import cpt_pkg::*;
(
  input wire cpt_pkg::cpt_entry_type entry,
  input wire logic [cpt_pkg::REG_W-1:0] new_src_a,
  input wire logic [cpt_pkg::REG_W-1:0] new_src_b,
  input wire logic [cpt_pkg::REG_W-1:0] new_dst,
  input wire logic new_reads_sr,
  output logic load_hit,
  output logic sr_hit
);
  always_comb begin
    load_hit = entry.valid && entry.cls == CLS_LOAD &&
               (entry.dst == new_src_a || entry.dst == new_src_b ||
                entry.dst == new_dst);
    sr_hit = entry.valid && entry.cls == CLS_SR_ARITH && new_reads_sr;
  end
endmodule : cpt_hazard_cmp

//--- cpt_issue_ctrl.sv
// Issue and stall control for the instruction pipeline.
// Assumes decoded instruction fields at issue and a memory path that
// raises fetch_req whenever the fetch unit wants the shared slot.

`timescale 1ns/1ps

module cpt_issue_ctrl
  import cpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic issue_valid,
  input wire cpt_pkg::cpt_class_type issue_class,
  input wire logic [cpt_pkg::REG_W-1:0] issue_src_a,
  input wire logic [cpt_pkg::REG_W-1:0] issue_src_b,
  input wire logic [cpt_pkg::REG_W-1:0] issue_dst,
  input wire logic issue_reads_sr,
  output logic issue_ready,
  input wire logic fetch_req,
  output logic fetch_grant,
  output logic data_grant,
  output logic done_valid,
  output logic [cpt_pkg::STG_W-1:0] done_stages,
  output logic [cpt_pkg::STG_W-1:0] done_base_cycles,
  output logic [cpt_pkg::CNT_W-1:0] done_stall_cycles,
  output logic wb_valid,
  output logic [cpt_pkg::REG_W-1:0] wb_dst
);
  import cpt_pkg::*;

  // ============================================================
  // State
  typedef struct packed {
    cpt_entry_type ex;
    cpt_entry_type ma;
    cpt_entry_type wb;
    cpt_slot_type slot;
    logic [CNT_W-1:0] stall_cnt;
    logic done_valid;
    logic [STG_W-1:0] done_stages;
    logic [STG_W-1:0] done_base;
    logic [CNT_W-1:0] done_stall;
  } cpt_state_type;

  cpt_state_type st_r;
  cpt_state_type st_nxt;

  logic load_hit_ex;
  logic load_hit_ma;
  logic sr_hit_ex;
  logic sr_hit_ma;
  logic mem_busy;
  logic conflict;
  logic advance;
  logic hazard;
  logic accept;

  // ============================================================
  // Hazard detection against the two stages ahead of issue
  cpt_hazard_cmp u_cmp_ex (
    .entry(st_r.ex),
    .new_src_a(issue_src_a),
    .new_src_b(issue_src_b),
    .new_dst(issue_dst),
    .new_reads_sr(issue_reads_sr),
    .load_hit(load_hit_ex),
    .sr_hit(sr_hit_ex)
  );

  cpt_hazard_cmp u_cmp_ma (
    .entry(st_r.ma),
    .new_src_a(issue_src_a),
    .new_src_b(issue_src_b),
    .new_dst(issue_dst),
    .new_reads_sr(issue_reads_sr),
    .load_hit(load_hit_ma),
    .sr_hit(sr_hit_ma)
  );

  // ============================================================
  // Slot arbitration and issue handshake
  always_comb begin
    mem_busy = st_r.ma.valid && cls_has_mem(st_r.ma.cls);
    conflict = mem_busy && fetch_req && st_r.slot == SLOT_NORMAL;
    // The whole pipe waits out the first half of a split slot.
    advance = ce && !conflict;
    hazard = load_hit_ex || load_hit_ma;
    hazard = hazard || sr_hit_ex || sr_hit_ma;
    issue_ready = advance && !hazard;
    accept = issue_ready && issue_valid;
    data_grant = ce && mem_busy && st_r.slot == SLOT_NORMAL;
    fetch_grant = ce && fetch_req &&
                  (st_r.slot == SLOT_SPLIT || !mem_busy);
  end

  // ============================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.done_valid = 1'b0;
    case (st_r.slot)
      SLOT_NORMAL: begin
        if (conflict) begin
          st_nxt.slot = SLOT_SPLIT;
        end
      end
      SLOT_SPLIT: begin
        st_nxt.slot = SLOT_NORMAL;
      end
      default: begin
        st_nxt.slot = SLOT_NORMAL;
      end
    endcase
    if (advance) begin
      st_nxt.ma = st_r.ex;
      st_nxt.wb = st_r.ma;
      st_nxt.wb.valid = st_r.ma.valid && cls_writes_reg(st_r.ma.cls);
      st_nxt.ex.valid = accept;
      st_nxt.ex.cls = issue_class;
      st_nxt.ex.dst = issue_dst;
    end
    if (accept) begin
      st_nxt.done_valid = 1'b1;
      st_nxt.done_base = BASE_CYCLES;
      st_nxt.done_stall = st_r.stall_cnt;
      st_nxt.done_stages = cls_stages(issue_class);
      st_nxt.stall_cnt = CNT_ZERO;
    end else if (issue_valid && st_r.stall_cnt != CNT_MAX) begin
      // Saturates so a long stall cannot wrap to a small figure.
      st_nxt.stall_cnt = st_r.stall_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r.ex <= '{valid: 1'b0, cls: CLS_REG_XFER, dst: REG_ZERO};
      st_r.ma <= '{valid: 1'b0, cls: CLS_REG_XFER, dst: REG_ZERO};
      st_r.wb <= '{valid: 1'b0, cls: CLS_REG_XFER, dst: REG_ZERO};
      st_r.slot <= SLOT_NORMAL;
      st_r.stall_cnt <= CNT_ZERO;
      st_r.done_valid <= 1'b0;
      st_r.done_stages <= STAGES_LONG;
      st_r.done_base <= BASE_CYCLES;
      st_r.done_stall <= CNT_ZERO;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs
  always_comb begin
    done_valid = st_r.done_valid;
    done_stages = st_r.done_stages;
    done_base_cycles = st_r.done_base;
    done_stall_cycles = st_r.done_stall;
    wb_valid = st_r.wb.valid;
    wb_dst = st_r.wb.dst;
  end
endmodule : cpt_issue_ctrl

//--- cpt_issue_ctrl_asserts.sv
// Checker of stage counts, hazard stalls and slot split.
// Assumes the bind at the foot attaches it to the issue control.
`timescale 1ns/1ps
// ============================================================
// Checks
module cpt_issue_ctrl_asserts
  import cpt_pkg::*;
(
  input wire logic clk_sys, srst, ce, issue_valid, issue_reads_sr,
  input wire cpt_pkg::cpt_class_type issue_class,
  input wire logic [REG_W-1:0] issue_src_a, issue_dst,
  input wire logic issue_ready, fetch_req, fetch_grant, data_grant,
  input wire logic done_valid,
  input wire logic [STG_W-1:0] done_stages, done_base_cycles
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire acc = ce && issue_valid && issue_ready;
  wire shrt = issue_class == CLS_STORE || issue_class == CLS_PREFETCH;
  chk_base_one: assert property (
    done_valid |-> done_base_cycles == BASE_CYCLES) else $error("bad base");
  chk_stage_count: assert property (
    acc |=> done_valid && done_stages == ($past(shrt) ? 3'h4 : 3'h5))
    else $error("bad stage count");
  chk_load_use: assert property (
    (acc && issue_class == CLS_LOAD) ##1 (issue_valid &&
    issue_src_a == $past(issue_dst)) |-> !issue_ready) else $error("no stall");
  chk_flag_read: assert property (
    (acc && issue_class == CLS_SR_ARITH) ##1 acc ##1
    (issue_valid && issue_reads_sr) |-> !issue_ready) else $error("no stall");
  chk_split_order: assert property (
    data_grant && fetch_req |-> !fetch_grant && !issue_ready ##1
    (!ce || (fetch_grant && !data_grant))) else $error("bad split");
  chk_done_cause: assert property (
    done_valid |-> $past(acc)) else $error("done without issue");
endmodule : cpt_issue_ctrl_asserts
bind cpt_issue_ctrl cpt_issue_ctrl_asserts chk_u (.clk_sys, .srst, .ce,
  .issue_valid, .issue_reads_sr, .issue_class, .issue_src_a, .issue_dst,
  .issue_ready, .fetch_req, .fetch_grant, .data_grant, .done_valid,
  .done_stages, .done_base_cycles);

//--- cpt_fetch_model.sv
// Fetch side of the shared memory slot.
// Assumes the bench raises want for fetch pressure.
`timescale 1ns/1ps
// ============================================================
// Fetch requester
module cpt_fetch_model (
  input wire logic clk_sys,
  input wire logic want,
  input wire logic fetch_grant,
  output logic fetch_req
);
  initial fetch_req = 1'b0;
  // request held until granted, so a split never loses a fetch.
  // Non-blocking, so the grant is the one that stood before the edge.
  always @(posedge clk_sys) begin
    fetch_req <= want || (fetch_req && !fetch_grant);
  end
endmodule : cpt_fetch_model

//--- cpt_issue_ctrl_bench.sv
// Bench of the issue control with a fetch model on the slot.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
// ============================================================
// Bench
module cpt_issue_ctrl_bench;
  import cpt_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, issue_valid = 1'b0;
  logic issue_reads_sr = 1'b0, want = 1'b0, issue_ready, fetch_req;
  logic fetch_grant, data_grant, done_valid, wb_valid;
  cpt_class_type issue_class = CLS_REG_XFER;
  logic [REG_W-1:0] issue_src_a = REG_ZERO, issue_dst = REG_ZERO, wb_dst;
  logic [STG_W-1:0] done_stages, done_base_cycles;
  logic [CNT_W-1:0] done_stall_cycles;
  logic [6:0] exp_q[$];
  logic [6:0] e;
  int n_mismatch = 0, cmp_count = 0;
  cpt_class_type row_c[7] = '{CLS_REG_XFER, CLS_LOAD, CLS_STORE,
    CLS_STORE_PREDEC, CLS_PREFETCH, CLS_REG_ARITH, CLS_SR_ARITH};
  logic [2:0] row_s[7] = '{3'h5, 3'h5, 3'h4, 3'h5, 3'h4, 3'h5, 3'h5};
  always #4 clk_sys = ~clk_sys;
  cpt_issue_ctrl dut_u (.clk_sys, .srst, .ce, .issue_valid, .issue_class,
    .issue_src_a, .issue_src_b(issue_src_a), .issue_dst, .issue_reads_sr,
    .issue_ready, .fetch_req, .fetch_grant, .data_grant, .done_valid,
    .done_stages, .done_base_cycles, .done_stall_cycles, .wb_valid, .wb_dst);
  cpt_fetch_model fm_u (.clk_sys, .want, .fetch_grant, .fetch_req);
  task automatic check(input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h", $time, seen);
    end
  endtask : check
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Expectation x is the stage count above the stall count.
  task automatic issue(input cpt_class_type c, input logic [6:0] x,
    input logic [REG_W-1:0] a, d, input logic s);
    logic rdy;
    issue_valid = 1'b1;
    issue_class = c;
    issue_src_a = a;
    issue_dst = d;
    issue_reads_sr = s;
    // Ready is judged mid-cycle, where it has settled before the edge.
    do begin
      @(negedge clk_sys);
      rdy = issue_ready === 1'b1 && ce === 1'b1;
      @(posedge clk_sys);
    end while (!rdy);
    exp_q.push_back(x);
    #1;
  endtask : issue
  task automatic end_test(input string nm);
    issue_valid = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 $display("test %s ended", nm);
  endtask : end_test
  // Sampled mid-cycle, away from the edge that launches the pulse.
  always @(negedge clk_sys) begin
    if (done_valid === 1'b1 && exp_q.size() == 0) begin
      check(16'h0001, 16'h0000);
    end else if (done_valid === 1'b1) begin
      e = exp_q.pop_front();
      check({6'h0, done_stages, done_base_cycles, done_stall_cycles},
        {6'h0, e[6:4], BASE_CYCLES, e[3:0]});
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 srst = 1'b0;
    check({done_valid, wb_valid, wb_dst, done_stages, done_base_cycles,
      done_stall_cycles}, {2'b00, REG_ZERO, STAGES_LONG, BASE_CYCLES, CNT_ZERO});
    end_test("reset");
    foreach (row_c[i]) issue(row_c[i], {row_s[i], 4'h0}, 4'h0, 4'(i + 1), 1'b0);
    end_test("classes");
    issue(CLS_LOAD, 7'h50, 4'h0, 4'h3, 1'b0);
    issue(CLS_REG_ARITH, 7'h52, 4'h3, 4'h4, 1'b0);
    end_test("load use");
    issue(CLS_SR_ARITH, 7'h50, 4'h0, 4'h5, 1'b0);
    issue(CLS_REG_XFER, 7'h52, 4'h0, 4'h6, 1'b1);
    issue(CLS_SR_ARITH, 7'h50, 4'h0, 4'h5, 1'b0);
    issue(CLS_REG_ARITH, 7'h50, 4'h0, 4'h7, 1'b0);
    issue(CLS_REG_XFER, 7'h51, 4'h0, 4'h6, 1'b1);
    end_test("flags");
    want = 1'b1;
    issue(CLS_STORE, 7'h40, 4'h0, 4'h9, 1'b0);
    issue(CLS_REG_ARITH, 7'h50, 4'h0, 4'ha, 1'b0);
    issue(CLS_REG_ARITH, 7'h51, 4'h0, 4'hb, 1'b0);
    want = 1'b0;
    end_test("split");
    ce = 1'b0;
    fork
      issue(CLS_LOAD, 7'h50, 4'h0, 4'hc, 1'b0);
      #25 ce = 1'b1;
    join
    end_test("clock enable");
    results();
  end
  // A hang stops here; the tests need about 0.5 us.
  initial begin
    #5000;
    n_mismatch++;
    results();
  end
endmodule : cpt_issue_ctrl_bench
